/* File: bench/tb_tone_transceiver_host_control.sv */
// testbench of the tone transceiver host control block
`timescale 1ns/1ps
module tb_tone_transceiver_host_control;
  localparam int unsigned TICKS = 20;
  // crystal period is seven system clocks here
  localparam int BURST_CLKS = TICKS * 7;

  typedef struct packed {
    logic [3:0] control_first;
    logic [3:0] control_second;
    logic [3:0] tx;
    logic [1:0] group;
    logic dec;
    logic ten;
  } ttxc_row_s;

  logic clk = 1'b0;
  logic xtal = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, rs, rw, oe, early, gt_o, gt_oe, pin_o, pin_oe, tone_en, dec_en;
  logic sig_valid = 1'b0;
  logic cp_tone = 1'b0;
  logic st_in = 1'b0;
  logic [3:0] dec_code = 4'h0;
  logic [3:0] wdat, rdat, tone_code, rd;
  logic [1:0] group;
  int miscompares = 0;
  int check_count = 0;
  int on_cnt = 0;
  int last_on = 0;
  int gap_cnt = 0;
  ttxc_row_s rows[4] = '{
    '{4'h1, 4'h1, 4'hA, 2'h3, 1'b1, 1'b1},
    '{4'h0, 4'h5, 4'h0, 2'h1, 1'b1, 1'b0},
    '{4'h3, 4'hD, 4'hC, 2'h2, 1'b0, 1'b1},
    '{4'h2, 4'h1, 4'h5, 2'h3, 1'b0, 1'b0}};

  always #20 clk = ~clk;
  int xtal_div = 0;

  // crystal moved on falling edges only, three clocks high, four low
  always @(negedge clk) begin
    xtal_div <= (xtal_div == 6) ? 0 : xtal_div + 1;
    xtal <= (xtal_div < 3);
  end

  ttxc_top #(.BURST_XTAL_TICKS(TICKS)) ttxc_top_inst (
    .SYS_CLK_I(clk), .RSTN_I(rst_n), .CS_N_I(cs_n), .REGISTER_SELECT_LINE_I(rs),
    .RW_I(rw), .DATA_I(wdat), .DATA_O(rdat), .DATA_OE_O(oe), .CRYSTAL_INPUT_I(xtal),
    .SIGNAL_VALID_I(sig_valid), .DECODED_CODE_I(dec_code), .CP_TONE_I(cp_tone),
    .EARLY_STEER_OUT_O(early), .STEER_GUARD_PIN_I(st_in), .STEER_GUARD_PIN_O(gt_o),
    .STEER_GUARD_PIN_OE_O(gt_oe), .INTERRUPT_TONE_PIN_O(pin_o),
    .INTERRUPT_TONE_PIN_OE_O(pin_oe), .TONE_ENABLE_O(tone_en), .TONE_CODE_O(tone_code),
    .TONE_GROUP_O(group), .DECODE_ENABLE_O(dec_en));

  ttxc_host_model ttxc_host_model_inst (
    .clk_i(clk), .cs_n_o(cs_n), .rs_o(rs), .rw_o(rw), .data_o(wdat),
    .data_i(rdat), .data_oe_i(oe));

  // ****************************************
  // burst and pause length monitor
  // ****************************************
  always @(posedge clk) begin
    if (tone_en === 1'b1) begin
      on_cnt <= on_cnt + 1;
      gap_cnt <= 0;
    end else begin
      if (on_cnt != 0) last_on <= on_cnt;
      on_cnt <= 0;
      if (pin_oe !== 1'b1) gap_cnt <= gap_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic sel, input logic [3:0] d);
    logic [3:0] dummy;
    ttxc_host_model_inst.access(sel, 1'b0, d, dummy);
  endtask

  task automatic rd_reg(input logic sel, output logic [3:0] v);
    ttxc_host_model_inst.access(sel, 1'b1, 4'h0, v);
    if (ttxc_host_model_inst.timed_out) begin
      miscompares++;
      print_verdict();
    end
  endtask

  // first with routing bit, second, then first again without it
  task automatic set_ctl(input logic [3:0] control_first, input logic [3:0] control_second);
    wr(1'b1, control_first | 4'h8);
    wr(1'b1, control_second);
    wr(1'b1, control_first);
  endtask

  task automatic wait_pin(input logic exp);
    int n;
    n = 0;
    while (pin_oe !== exp && n < 700) begin
      @(negedge clk);
      n++;
    end
    if (n == 700) begin
      miscompares++;
      print_verdict();
    end
  endtask

  task automatic in_range(input string what, input int v, input int lo, input int hi);
    check(what, 16'(v >= lo && v <= hi), 16'h1);
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("group", group, 2'h3);
    check("decode", dec_en, 1'b1);
    check("tone", tone_en, 1'b0);
    check("pin level", pin_o, 1'b0);
    check("pin pull", pin_oe, 1'b0);
    check("bus drive", oe, 1'b0);
    rd_reg(1'b1, rd);
    check("status", rd, 4'h8);
    $display("test reset done");
    foreach (rows[i]) begin
      set_ctl(rows[i].control_first, rows[i].control_second);
      wr(1'b0, rows[i].tx);
      check("group", group, rows[i].group);
      check("decode", dec_en, rows[i].dec);
      check("tone", tone_en, rows[i].ten);
      check("code", tone_code, rows[i].tx);
    end
    $display("test control rows done");
    set_ctl(4'h5, 4'h0);
    wr(1'b0, 4'h7);
    wait_pin(1'b1);
    // start falls anywhere inside a crystal period
    in_range("burst", last_on, BURST_CLKS - 6, BURST_CLKS);
    in_range("pause", gap_cnt, BURST_CLKS - 3, BURST_CLKS + 6);
    rd_reg(1'b1, rd);
    check("status", rd, 4'hB);
    rd_reg(1'b1, rd);
    check("status", rd, 4'h8);
    check("pin pull", pin_oe, 1'b0);
    check("bus drive", oe, 1'b0);
    $display("test burst done");
    set_ctl(4'h7, 4'h0);
    wr(1'b0, 4'h2);
    repeat (600) @(negedge clk);
    in_range("long burst", last_on, 2 * BURST_CLKS - 6, 2 * BURST_CLKS);
    check("decode", dec_en, 1'b0);
    cp_tone = 1'b1;
    repeat (5) @(negedge clk);
    check("pin pull", pin_oe, 1'b0);
    cp_tone = 1'b0;
    repeat (5) @(negedge clk);
    check("pin pull", pin_oe, 1'b1);
    // steering in call-progress mode must not latch a code
    dec_code = 4'h3;
    st_in = 1'b1;
    repeat (8) @(negedge clk);
    st_in = 1'b0;
    rd_reg(1'b0, rd);
    check("rx code", rd, 4'h0);
    set_ctl(4'h7, 4'h1);
    rd_reg(1'b1, rd);
    check("status", rd, 4'h9);
    $display("test call progress done");
    set_ctl(4'h4, 4'h1);
    dec_code = 4'hB;
    sig_valid = 1'b1;
    repeat (4) @(negedge clk);
    check("early", early, 1'b1);
    st_in = 1'b1;
    wait_pin(1'b1);
    check("pin level", pin_o, 1'b0);
    check("guard drive", gt_oe, 1'b1);
    check("guard value", gt_o, 1'b1);
    rd_reg(1'b0, rd);
    check("rx code", rd, 4'hB);
    rd_reg(1'b1, rd);
    check("status", rd, 4'h5);
    rd_reg(1'b1, rd);
    check("status", rd, 4'h0);
    sig_valid = 1'b0;
    repeat (4) @(negedge clk);
    check("early", early, 1'b0);
    check("guard value", gt_o, 1'b0);
    st_in = 1'b0;
    wait_pin(1'b0);
    check("guard drive", gt_oe, 1'b0);
    rd_reg(1'b1, rd);
    check("status", rd, 4'h8);
    $display("test receive done");
    // tone-pair mode is already selected before test mode
    set_ctl(4'h0, 4'h3);
    check("pin pull", pin_oe, 1'b0);
    st_in = 1'b1;
    wait_pin(1'b1);
    $display("test test mode done");
    // reset in mid-run must drop test mode and interrupt enable
    st_in = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("pin pull", pin_oe, 1'b0);
    rst_n = 1'b1;
    @(negedge clk);
    check("group", group, 2'h3);
    check("decode", dec_en, 1'b1);
    rd_reg(1'b1, rd);
    check("status", rd, 4'h8);
    st_in = 1'b1;
    repeat (8) @(negedge clk);
    check("pin pull", pin_oe, 1'b0);
    st_in = 1'b0;
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule

/* File: bench/ttxc_host_model.sv */
// host processor model on the 4-bit register bus
`timescale 1ns/1ps
module ttxc_host_model (
  // clock
  input wire logic clk_i,
  // bus towards the device
  output logic cs_n_o,
  output logic rs_o,
  output logic rw_o,
  output logic [3:0] data_o,
  // answer from the device
  input wire logic [3:0] data_i,
  input wire logic data_oe_i
);
  logic timed_out = 1'b0;

  initial begin
    cs_n_o = 1'b1;
    rs_o = 1'b0;
    rw_o = 1'b1;
    data_o = 4'hF;
  end

  // ****************************************
  // one access: select held, then idle gap
  // ****************************************
  task automatic access(input logic rs, input logic rw, input logic [3:0] wdata,
                        output logic [3:0] rdata);
    int n;
    n = 0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    rs_o = rs;
    rw_o = rw;
    data_o = wdata;
    repeat (4) @(negedge clk_i);
    while (rw && data_oe_i !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 8) begin
      timed_out = 1'b1;
    end
    rdata = data_i;
    cs_n_o = 1'b1;
    // released data lines show no stale value
    data_o = ~wdata;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

/* File: rtl/ttxc_burst_timer.sv */
// burst and pause sequencer counted in crystal periods
`timescale 1ns/1ps
`include "ttxc_params.svh"
module ttxc_burst_timer #(
  parameter int unsigned TICKS = `TTXC_BURST_XTAL_TICKS,
  parameter int unsigned CW = `TTXC_TIMER_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic double_i,
  input wire logic abort_i,
  // results
  output logic burst_o,
  output logic done_o
);

  ttxc_pkg::ttxc_phase_e phase_q;
  logic [CW-1:0] cnt_q;
  logic double_q;
  logic [CW-1:0] last;
  logic at_end;

  assign last = double_q ? CW'(2 * TICKS - 1) : CW'(TICKS - 1);
  assign at_end = tick_i && (cnt_q == last);

  // ****************************************
  // phase sequencing
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= ttxc_pkg::PH_IDLE;
      cnt_q <= '0;
      double_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        phase_q <= ttxc_pkg::PH_IDLE;
        cnt_q <= '0;
      end else if (start_i) begin
        phase_q <= ttxc_pkg::PH_BURST;
        cnt_q <= '0;
        double_q <= double_i;
      end else if (tick_i) begin
        case (phase_q)
          ttxc_pkg::PH_BURST: begin
            cnt_q <= at_end ? '0 : cnt_q + 1'b1;
            if (at_end) begin
              phase_q <= ttxc_pkg::PH_PAUSE;
            end
          end
          ttxc_pkg::PH_PAUSE: begin
            cnt_q <= at_end ? '0 : cnt_q + 1'b1;
            if (at_end) begin
              phase_q <= ttxc_pkg::PH_IDLE;
              done_o <= 1'b1;
            end
          end
          default: cnt_q <= '0;
        endcase
      end
    end
  end

  assign burst_o = (phase_q == ttxc_pkg::PH_BURST);

  // ****************************************
  // checks
  // ****************************************
  burst_to_pause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    phase_q == ttxc_pkg::PH_BURST && at_end && !start_i && !abort_i
    |=> phase_q == ttxc_pkg::PH_PAUSE && cnt_q == '0)
    else $error("burst did not turn into pause at its end");

  count_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_q <= CW'(2 * TICKS - 1))
    else $error("burst counter ran past the doubled length");

endmodule

/* File: rtl/ttxc_params.svh */
// constants of the tone transceiver control block
`ifndef TTXC_PARAMS_SVH
`define TTXC_PARAMS_SVH

// ****************************************
// register select and reset values
// ****************************************
`define TTXC_RS_DATA 1'h0
`define TTXC_RS_CTRL 1'h1
`define TTXC_CRA_RST 4'h0
`define TTXC_CRB_RST 4'h0
`define TTXC_TX_RST 4'h0
`define TTXC_RX_RST 4'h0
`define TTXC_STAT_RST 4'h8

// ****************************************
// field positions
// ****************************************
`define TTXC_STAT_IRQ 0
`define TTXC_STAT_TXE 1
`define TTXC_STAT_RXF 2
`define TTXC_STAT_DST 3

// ****************************************
// input synchroniser bundle
// ****************************************
`define TTXC_SYNC_W 15
`define TTXC_SYNC_RST 15'h4000

// ****************************************
// burst timing, counted in crystal periods
// ****************************************
`define TTXC_BURST_MS 51
`define TTXC_XTAL_HZ 3579545
`define TTXC_BURST_XTAL_TICKS ((`TTXC_BURST_MS * `TTXC_XTAL_HZ) / 1000)
`define TTXC_TIMER_W 20

`endif

/* File: rtl/ttxc_pkg.sv */
// types of the tone transceiver control block
package ttxc_pkg;

  // ****************************************
  // register access kinds
  // ****************************************
  typedef enum logic [1:0] {REG_TX_WR, REG_RX_RD, REG_CTL_WR, REG_STAT_RD} ttxc_reg_e;

  // ****************************************
  // burst sequencer phases
  // ****************************************
  typedef enum logic [1:0] {PH_IDLE, PH_BURST, PH_PAUSE} ttxc_phase_e;

  // ****************************************
  // control and status layouts
  // ****************************************
  typedef struct packed {
    logic second_control_select;
    logic irq_enable;
    logic call_progress_select;
    logic tone_output_enable;
  } ttxc_cra_s;

  typedef struct packed {
    logic column_select;
    logic single_tone;
    logic test_mode;
    logic burst_off;
  } ttxc_crb_s;

  typedef struct packed {
    logic delayed_steer;
    logic rx_full;
    logic tx_empty;
    logic irq;
  } ttxc_stat_s;

endpackage

/* File: rtl/ttxc_top.sv */
// ttxc_top: host registers and control of the tone signalling transceiver
// What this block does
// - burst and pause each last 51 ms in tone-pair burst timing
// - call-progress with burst timing doubles both to 102 ms, no decoding
// - reset clears both control registers: tone-pair mode, burst timing
// - select/direction pick transmit, receive, control or status
// - first control bit 3 sends only the next control write to second
// - first control bit 0 enables or silences the tone output
// - first control bit 1 picks tone-pair or call-progress mode
// - call-progress with interrupt enable puts the tone square wave on the pin
// - tone-pair interrupt pulls the pin on held pair or transmitter ready
// - burst timing: code write starts burst and pause, then ready flag
// - test mode puts inverted delayed steering on the pin; delayed steering only rises in tone-pair mode
// - second control bit 2 picks dual or single tone
// - second control bit 3 picks low group or high group single tone
// - status bit 0 set with bit 1 or 2, cleared by status read
// - status bit 1 set at pause end, cleared by read or no burst
// - status bit 2 set on new received code, cleared by read
// - status bit 3 set on tone absence, cleared on tone detection
// - receive code read only, transmit code write only
// - interrupt pin only pulls low or releases
// - transfers only under chip select, direction set by read/write
// - early steering follows the detector signal condition
// - transmit and receive share one 4-bit digit code
// - receive code latched on steering input rise in tone-pair mode, pin low on delayed steering with interrupt enable or in test mode
`timescale 1ns/1ps
`include "ttxc_params.svh"
module ttxc_top #(
  parameter int unsigned BURST_XTAL_TICKS = `TTXC_BURST_XTAL_TICKS
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  // host bus
  input wire logic CS_N_I,
  input wire logic REGISTER_SELECT_LINE_I,
  input wire logic RW_I,
  input wire logic [3:0] DATA_I,
  output logic [3:0] DATA_O,
  output logic DATA_OE_O,
  // crystal oscillator
  input wire logic CRYSTAL_INPUT_I,
  // receiver front end
  input wire logic SIGNAL_VALID_I,
  input wire logic [3:0] DECODED_CODE_I,
  input wire logic CP_TONE_I,
  output logic EARLY_STEER_OUT_O,
  // steering input and guard time output
  input wire logic STEER_GUARD_PIN_I,
  output logic STEER_GUARD_PIN_O,
  output logic STEER_GUARD_PIN_OE_O,
  // interrupt and call progress pin, open drain
  output logic INTERRUPT_TONE_PIN_O,
  output logic INTERRUPT_TONE_PIN_OE_O,
  // tone generator control
  output logic TONE_ENABLE_O,
  output logic [3:0] TONE_CODE_O,
  output logic [1:0] TONE_GROUP_O,
  output logic DECODE_ENABLE_O
);

  // ****************************************
  // declarations
  // ****************************************
  localparam logic [`TTXC_SYNC_W-1:0] SYNC_RST = `TTXC_SYNC_RST;

  logic [`TTXC_SYNC_W-1:0] pins;
  logic [`TTXC_SYNC_W-1:0] sync1_q;
  logic [`TTXC_SYNC_W-1:0] sync2_q;
  logic cs_act, rs_s, rw_s, xtal_s, est_s, cptone_s, st_s;
  logic [3:0] data_s, code_s;
  logic cs_act_q, xtal_q, st_q;
  logic acc_begin, acc_end;
  ttxc_pkg::ttxc_reg_e acc_q;
  logic [3:0] wr_data_q;
  logic [3:0] snap_q;
  ttxc_pkg::ttxc_cra_s cra_q;
  ttxc_pkg::ttxc_crb_s crb_q;
  logic to_second_q;
  logic [3:0] tx_code_q;
  logic [3:0] rx_code_q;
  ttxc_pkg::ttxc_stat_s stat_q;
  ttxc_pkg::ttxc_stat_s stat_d;
  logic dly_q;
  logic tx_wr, ctl_wr, stat_rd;
  logic xtal_tick, steer_rise, burst_mode;
  logic tmr_burst, tmr_done;
  logic pull_d;

  // ****************************************
  // register access decode
  // ****************************************
  function automatic ttxc_pkg::ttxc_reg_e reg_decode(input logic rs, input logic rw);
    ttxc_pkg::ttxc_reg_e r;
    r = ttxc_pkg::REG_TX_WR;
    if (rs == `TTXC_RS_DATA) begin
      r = rw ? ttxc_pkg::REG_RX_RD : ttxc_pkg::REG_TX_WR;
    end else begin
      r = rw ? ttxc_pkg::REG_STAT_RD : ttxc_pkg::REG_CTL_WR;
    end
    return r;
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  assign pins = {CS_N_I, REGISTER_SELECT_LINE_I, RW_I, DATA_I, CRYSTAL_INPUT_I,
                 SIGNAL_VALID_I, DECODED_CODE_I, CP_TONE_I, STEER_GUARD_PIN_I};

  genvar gi;
  generate
    for (gi = 0; gi < `TTXC_SYNC_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          sync1_q[gi] <= SYNC_RST[gi];
          sync2_q[gi] <= SYNC_RST[gi];
        end else begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign cs_act = ~sync2_q[14];
  assign rs_s = sync2_q[13];
  assign rw_s = sync2_q[12];
  assign data_s = sync2_q[11:8];
  assign xtal_s = sync2_q[7];
  assign est_s = sync2_q[6];
  assign code_s = sync2_q[5:2];
  assign cptone_s = sync2_q[1];
  assign st_s = sync2_q[0];

  // ****************************************
  // edge detection
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cs_act_q <= 1'b0;
      xtal_q <= 1'b0;
      st_q <= 1'b0;
    end else begin
      cs_act_q <= cs_act;
      xtal_q <= xtal_s;
      st_q <= st_s;
    end
  end

  assign acc_begin = cs_act && !cs_act_q;
  assign acc_end = !cs_act && cs_act_q;
  assign xtal_tick = xtal_s && !xtal_q;
  assign steer_rise = st_s && !st_q && !cra_q.call_progress_select;
  assign tx_wr = acc_end && (acc_q == ttxc_pkg::REG_TX_WR);
  assign ctl_wr = acc_end && (acc_q == ttxc_pkg::REG_CTL_WR);
  assign stat_rd = acc_end && (acc_q == ttxc_pkg::REG_STAT_RD);
  assign burst_mode = !crb_q.burst_off;

  // ****************************************
  // bus access and read data
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      acc_q <= ttxc_pkg::REG_TX_WR;
      wr_data_q <= 4'h0;
      snap_q <= 4'h0;
      DATA_O <= 4'h0;
      DATA_OE_O <= 1'b0;
    end else begin
      if (acc_begin) begin
        acc_q <= reg_decode(rs_s, rw_s);
        case (reg_decode(rs_s, rw_s))
          ttxc_pkg::REG_RX_RD: DATA_O <= rx_code_q;
          ttxc_pkg::REG_STAT_RD: DATA_O <= stat_q;
          default: DATA_O <= 4'h0;
        endcase
        snap_q <= (reg_decode(rs_s, rw_s) == ttxc_pkg::REG_STAT_RD) ? stat_q : 4'h0;
      end
      if (cs_act) begin
        wr_data_q <= data_s;
      end
      DATA_OE_O <= cs_act && rw_s;
    end
  end

  // ****************************************
  // transmit code and control registers
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_code_q <= `TTXC_TX_RST;
      cra_q <= `TTXC_CRA_RST;
      crb_q <= `TTXC_CRB_RST;
      to_second_q <= 1'b0;
    end else begin
      if (tx_wr) begin
        tx_code_q <= wr_data_q;
      end
      if (ctl_wr) begin
        if (to_second_q) begin
          crb_q <= wr_data_q;
          to_second_q <= 1'b0;
        end else begin
          cra_q <= wr_data_q;
          to_second_q <= wr_data_q[3];
        end
      end
    end
  end

  // ****************************************
  // receive latch and delayed steering
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_code_q <= `TTXC_RX_RST;
      dly_q <= 1'b0;
    end else begin
      if (steer_rise) begin
        rx_code_q <= code_s;
      end
      if (!st_s) begin
        dly_q <= 1'b0;
      end else if (st_q && !cra_q.call_progress_select) begin
        dly_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // status flags, set wins over read clear
  // ****************************************
  always_comb begin
    stat_d = stat_q;
    if (stat_rd) begin
      stat_d.tx_empty = stat_q.tx_empty & ~snap_q[`TTXC_STAT_TXE];
      stat_d.rx_full = stat_q.rx_full & ~snap_q[`TTXC_STAT_RXF];
      stat_d.irq = stat_q.irq & ~snap_q[`TTXC_STAT_IRQ];
    end
    if (!burst_mode) begin
      stat_d.tx_empty = 1'b0;
    end else if (tmr_done) begin
      stat_d.tx_empty = 1'b1;
    end
    if (steer_rise) begin
      stat_d.rx_full = 1'b1;
    end
    if (stat_d.tx_empty || stat_d.rx_full) begin
      stat_d.irq = 1'b1;
    end
    stat_d.delayed_steer = ~dly_q;
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stat_q <= `TTXC_STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // ****************************************
  // burst sequencer
  // ****************************************
  ttxc_burst_timer #(
    .TICKS(BURST_XTAL_TICKS),
    .CW(`TTXC_TIMER_W)
  ) u_timer (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RSTN_I),
    .tick_i(xtal_tick),
    .start_i(tx_wr && burst_mode),
    .double_i(cra_q.call_progress_select),
    .abort_i(!burst_mode),
    .burst_o(tmr_burst),
    .done_o(tmr_done)
  );

  // ****************************************
  // shared interrupt pin
  // ****************************************
  always_comb begin
    if (crb_q.test_mode) begin
      pull_d = dly_q;
    end else if (cra_q.call_progress_select) begin
      pull_d = cra_q.irq_enable && !cptone_s;
    end else begin
      pull_d = cra_q.irq_enable && (dly_q || stat_q.tx_empty);
    end
  end

  // ****************************************
  // output flops
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      INTERRUPT_TONE_PIN_O <= 1'b0;
      INTERRUPT_TONE_PIN_OE_O <= 1'b0;
      EARLY_STEER_OUT_O <= 1'b0;
      STEER_GUARD_PIN_O <= 1'b0;
      STEER_GUARD_PIN_OE_O <= 1'b0;
      TONE_ENABLE_O <= 1'b0;
      TONE_CODE_O <= `TTXC_TX_RST;
      TONE_GROUP_O <= 2'h3;
      DECODE_ENABLE_O <= 1'b1;
    end else begin
      INTERRUPT_TONE_PIN_O <= 1'b0;
      INTERRUPT_TONE_PIN_OE_O <= pull_d;
      EARLY_STEER_OUT_O <= est_s;
      STEER_GUARD_PIN_O <= est_s;
      STEER_GUARD_PIN_OE_O <= st_s;
      TONE_ENABLE_O <= cra_q.tone_output_enable && (crb_q.burst_off || tmr_burst);
      TONE_CODE_O <= tx_code_q;
      if (crb_q.single_tone) begin
        TONE_GROUP_O <= crb_q.column_select ? 2'h2 : 2'h1;
      end else begin
        TONE_GROUP_O <= 2'h3;
      end
      DECODE_ENABLE_O <= !cra_q.call_progress_select;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence ctl_wr_second_s;
    ctl_wr && to_second_q;
  endsequence

  sequence ctl_wr_first_s;
    ctl_wr && !to_second_q;
  endsequence

  route_second_a: assert property (ctl_wr_second_s |=> crb_q == $past(wr_data_q)
    && !to_second_q)
    else $error("second control write not routed");

  route_first_a: assert property (ctl_wr_first_s |=> $stable(crb_q)
    && cra_q == $past(wr_data_q))
    else $error("second control changed by first control writes");

  reset_ctrl_a: assert property (disable iff (1'b0) !RSTN_I |=> cra_q == 4'h0
    && crb_q == 4'h0)
    else $error("control registers not cleared by reset");

  tone_gate_a: assert property (!cra_q.tone_output_enable |=> !TONE_ENABLE_O)
    else $error("tone output on while gated off");

  no_decode_cp_a: assert property (cra_q.call_progress_select && $stable(cra_q)
    |=> $stable(rx_code_q))
    else $error("receive code changed in call progress mode");

  irq_sum_a: assert property ((stat_q.tx_empty || stat_q.rx_full) |-> stat_q.irq)
    else $error("interrupt flag clear while a source flag is set");

  txe_clear_a: assert property (crb_q.burst_off |=> !stat_q.tx_empty)
    else $error("transmit ready flag outside burst timing");

  txe_set_a: assert property (tmr_done && burst_mode |=> stat_q.tx_empty
    && stat_q.irq)
    else $error("pause end did not raise ready");

  rx_full_a: assert property (steer_rise |=> stat_q.rx_full ##2 (!stat_q.delayed_steer
    || !st_s))
    else $error("receive flag or steering status not updated");

  dst_set_a: assert property (!st_s |=> ##1 stat_q.delayed_steer)
    else $error("steering status not set on tone absence");

  pin_od_a: assert property (!INTERRUPT_TONE_PIN_O)
    else $error("interrupt pin driven high");

  cp_pin_a: assert property (cra_q.call_progress_select && cra_q.irq_enable
    && !crb_q.test_mode |=> INTERRUPT_TONE_PIN_OE_O == !$past(cptone_s))
    else $error("pin does not follow call progress tone");

  test_pin_a: assert property (crb_q.test_mode |=> INTERRUPT_TONE_PIN_OE_O == $past(dly_q))
    else $error("test mode pin wrong");

  irq_pull_a: assert property (!crb_q.test_mode && !cra_q.call_progress_select
    && cra_q.irq_enable && dly_q |=> INTERRUPT_TONE_PIN_OE_O)
    else $error("interrupt pin not pulled for held tone pair");

  single_tone_a: assert property (crb_q.single_tone |=> TONE_GROUP_O != 2'h3)
    else $error("dual tone produced in single tone mode");

  early_steer_a: assert property (est_s |=> EARLY_STEER_OUT_O ##1 EARLY_STEER_OUT_O
    || !$past(est_s))
    else $error("early steering does not follow detector");

  bus_idle_a: assert property (!cs_act |=> !DATA_OE_O)
    else $error("data driven without chip select");

endmodule
